// ===== logic/srpc_pkg.sv
// shared constants for the stall prevention ramp supervisor
package srpc_pkg;

  // ********************************
  // register indices and byte addresses
  // ********************************
  localparam logic [15:0] IDX_OV_THR = 16'h0601;
  localparam logic [15:0] IDX_OV_METHOD = 16'h0602;
  localparam logic [15:0] IDX_ACC_THR = 16'h0603;
  localparam logic [15:0] IDX_RUN_THR = 16'h0604;
  localparam logic [15:0] IDX_RAMP_SEL = 16'h0605;
  localparam logic [15:0] IDX_CTRL = 16'h0610;
  localparam logic [15:0] IDX_RATED = 16'h0611;
  localparam logic [15:0] IDX_STATUS = 16'h0612;
  localparam logic [15:0] ADDR_OV_THR = 16'(IDX_OV_THR << 2);
  localparam logic [15:0] ADDR_OV_METHOD = 16'(IDX_OV_METHOD << 2);
  localparam logic [15:0] ADDR_ACC_THR = 16'(IDX_ACC_THR << 2);
  localparam logic [15:0] ADDR_RUN_THR = 16'(IDX_RUN_THR << 2);
  localparam logic [15:0] ADDR_RAMP_SEL = 16'(IDX_RAMP_SEL << 2);
  localparam logic [15:0] ADDR_CTRL = 16'(IDX_CTRL << 2);
  localparam logic [15:0] ADDR_RATED = 16'(IDX_RATED << 2);
  localparam logic [15:0] ADDR_STATUS = 16'(IDX_STATUS << 2);

  // ********************************
  // field positions
  // ********************************
  localparam int CTRL_DUTY_BIT = 0;
  localparam int CTRL_CLASS_LSB = 1;
  localparam int ST_OV_BIT = 0;
  localparam int ST_OC_BIT = 1;
  localparam int ST_REDUCE_BIT = 2;
  localparam int ST_RECOVER_BIT = 3;
  localparam int ST_FREQ_LSB = 16;

  // ********************************
  // reset values and limits (percent, 0.1 V units)
  // ********************************
  localparam logic [15:0] RST_OV_THR = 16'h0ED8;
  localparam logic RST_OV_METHOD = 1'b0;
  localparam logic [2:0] RST_RAMP_SEL = 3'h0;
  localparam logic RST_DUTY = 1'b0;
  localparam logic [1:0] RST_CLASS = 2'h0;
  localparam logic [15:0] RST_RATED = 16'h0100;
  localparam logic [15:0] DEF_THR_VT = 16'h0078;
  localparam logic [15:0] DEF_THR_CT = 16'h00B4;
  localparam logic [15:0] MAX_PCT_VT = 16'h0096;
  localparam logic [15:0] MAX_PCT_CT = 16'h00C8;
  localparam logic [15:0] CAP_PCT_HIGH_BUS = 16'h00B9;
  localparam logic [15:0] BUS_LVL_CLASS0 = 16'h0DAC;
  localparam logic [15:0] BUS_LVL_CLASS1 = 16'h1B58;
  localparam logic [15:0] BUS_LVL_CLASS2 = 16'h222E;
  localparam logic [15:0] SMART_MARGIN = 16'h0064;
  localparam logic [2:0] RAMP_SEL_AUTO = 3'h5;

  // ********************************
  // supervisor states
  // ********************************
  typedef enum logic [2:0] {
    ST_NORMAL = 3'b001,
    ST_REDUCE = 3'b010,
    ST_RECOVER = 3'b100
  } srpc_state_t;

endpackage

// ===== logic/srpc_limit.sv
// scales a percent threshold by the rated current into a registered limit
module srpc_limit
  import srpc_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [15:0] pct,
  input wire logic [15:0] rated,
  output logic [15:0] limit_q
);

  typedef struct packed {
    logic [15:0] limit;
  } srpc_lim_t;

  srpc_lim_t r_q;
  srpc_lim_t r_d;
  logic [31:0] scaled;

  always_comb begin
    r_d = r_q;
    scaled = (32'(pct) * 32'(rated)) / 32'd100;
    if (scaled[31:16] != 16'h0000) begin
      r_d.limit = 16'hFFFF;
    end else begin
      r_d.limit = scaled[15:0];
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign limit_q = r_q.limit;

endmodule

// ===== logic/srpc_ramp_ctrl.sv
// stall prevention ramp supervisor with apb register file
// Notes on behaviour
// - method 0 holds decel, 1 regulates bus
// - traditional: freeze decel while bus above threshold
// - smart: slow decel rate near threshold
// - zero bus threshold disables over-voltage prevention
// - thresholds capped 150 or 200 percent
// - accel threshold defaults 120 or 180
// - constant torque, high bus: cap 185 percent
// - accel over limit holds output frequency
// - steady over limit lowers frequency, selected ramp
// - below limit ramps back to command
// - ramp selector: active, sets 1-4, auto
module srpc_ramp_ctrl
  import srpc_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] outputCurrent,
  input wire logic [15:0] busVoltage,
  input wire logic [15:0] cmdFreq,
  input wire logic [15:0] rateActive,
  input wire logic [15:0] rateSet1,
  input wire logic [15:0] rateSet2,
  input wire logic [15:0] rateSet3,
  input wire logic [15:0] rateSet4,
  input wire logic [15:0] rateAuto,
  output logic [15:0] outFreq,
  output logic ovStallActive,
  output logic ocStallActive
);

  // ********************************
  // state
  // ********************************
  typedef struct packed {
    logic [15:0] curMeta;
    logic [15:0] curSync;
    logic [15:0] busMeta;
    logic [15:0] busSync;
    logic [15:0] ovThr;
    logic ovMethod;
    logic [15:0] accThr;
    logic [15:0] runThr;
    logic [2:0] rampSel;
    logic torqueDuty;
    logic [1:0] voltClass;
    logic [15:0] ratedCur;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [31:0] freqAcc;
    logic [15:0] outFreq;
    logic ovStall;
    logic ocStall;
    srpc_state_t state;
  } srpc_regs_t;

  srpc_regs_t r_q;
  srpc_regs_t r_d;
  logic [15:0] accLimit;
  logic [15:0] runLimit;
  logic [15:0] effAcc;
  logic [15:0] effRun;
  logic [15:0] busLevel;
  logic capHigh;
  logic ovEn;
  logic busHigh;
  logic busNear;
  logic accHigh;
  logic runHigh;
  logic accelReq;
  logic decelReq;
  logic [31:0] target;
  logic [15:0] selRate;
  logic [15:0] maxPct;
  logic [15:0] wrPct;
  logic [15:0] dutyDef;
  logic access;
  logic mapped;

  // ********************************
  // ramp time selection
  // ********************************
  // decode ramp selector
  always_comb begin
    unique case (r_q.rampSel)
      3'h1: selRate = rateSet1;
      3'h2: selRate = rateSet2;
      3'h3: selRate = rateSet3;
      3'h4: selRate = rateSet4;
      RAMP_SEL_AUTO: selRate = rateAuto;
      default: selRate = rateActive;
    endcase
  end

  // ********************************
  // thresholds and comparisons
  // ********************************
  always_comb begin
    unique case (r_q.voltClass)
      2'h0: busLevel = BUS_LVL_CLASS0;
      2'h1: busLevel = BUS_LVL_CLASS1;
      default: busLevel = BUS_LVL_CLASS2;
    endcase
  end

  // high bus cap in constant torque
  assign capHigh = r_q.torqueDuty && (r_q.busSync > busLevel);
  assign effAcc = (capHigh && r_q.accThr > CAP_PCT_HIGH_BUS) ? CAP_PCT_HIGH_BUS : r_q.accThr;
  assign effRun = (capHigh && r_q.runThr > CAP_PCT_HIGH_BUS) ? CAP_PCT_HIGH_BUS : r_q.runThr;

  srpc_limit uAccLimit (
    .mclk(mclk),
    .arst_n(arst_n),
    .pct(effAcc),
    .rated(r_q.ratedCur),
    .limit_q(accLimit)
  );

  srpc_limit uRunLimit (
    .mclk(mclk),
    .arst_n(arst_n),
    .pct(effRun),
    .rated(r_q.ratedCur),
    .limit_q(runLimit)
  );

  assign ovEn = r_q.ovThr != 16'h0000;
  assign busHigh = r_q.busSync > r_q.ovThr;
  assign busNear = (r_q.ovThr > SMART_MARGIN) ? (r_q.busSync > r_q.ovThr - SMART_MARGIN) : 1'b1;
  assign accHigh = r_q.curSync > accLimit;
  assign runHigh = r_q.curSync > runLimit;
  assign target = {cmdFreq, 16'h0000};
  assign accelReq = r_q.freqAcc < target;
  assign decelReq = r_q.freqAcc > target;

  // ********************************
  // apb decode
  // ********************************
  assign access = psel && penable && r_q.pready;
  always_comb begin
    unique case (paddr)
      ADDR_OV_THR, ADDR_OV_METHOD, ADDR_ACC_THR, ADDR_RUN_THR: mapped = 1'b1;
      ADDR_RAMP_SEL, ADDR_CTRL, ADDR_RATED, ADDR_STATUS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign maxPct = r_q.torqueDuty ? MAX_PCT_CT : MAX_PCT_VT;
  assign wrPct = (pwdata[15:0] > maxPct) ? maxPct : pwdata[15:0];
  assign dutyDef = pwdata[CTRL_DUTY_BIT] ? DEF_THR_CT : DEF_THR_VT;

  // ********************************
  // next state
  // ********************************
  always_comb begin
    logic [32:0] upSum;
    logic [31:0] upStep;
    logic [31:0] downStep;
    logic [31:0] stepRate;
    upSum = '0;
    upStep = '0;
    downStep = '0;
    stepRate = '0;
    r_d = r_q;
    r_d.curMeta = outputCurrent;
    r_d.curSync = r_q.curMeta;
    r_d.busMeta = busVoltage;
    r_d.busSync = r_q.busMeta;
    r_d.pready = psel && !penable;
    r_d.pslverr = psel && !penable && !mapped;
    if (psel && !penable) begin
      unique case (paddr)
        ADDR_OV_THR: r_d.prdata = {16'h0000, r_q.ovThr};
        ADDR_OV_METHOD: r_d.prdata = {31'h0, r_q.ovMethod};
        ADDR_ACC_THR: r_d.prdata = {16'h0000, r_q.accThr};
        ADDR_RUN_THR: r_d.prdata = {16'h0000, r_q.runThr};
        ADDR_RAMP_SEL: r_d.prdata = {29'h0, r_q.rampSel};
        ADDR_CTRL: r_d.prdata = {29'h0, r_q.voltClass, r_q.torqueDuty};
        ADDR_RATED: r_d.prdata = {16'h0000, r_q.ratedCur};
        ADDR_STATUS: begin
          r_d.prdata = '0;
          r_d.prdata[ST_FREQ_LSB +: 16] = r_q.outFreq;
          r_d.prdata[ST_OV_BIT] = r_q.ovStall;
          r_d.prdata[ST_OC_BIT] = r_q.ocStall;
          r_d.prdata[ST_REDUCE_BIT] = r_q.state == ST_REDUCE;
          r_d.prdata[ST_RECOVER_BIT] = r_q.state == ST_RECOVER;
        end
        default: r_d.prdata = '0;
      endcase
    end
    if (access && pwrite) begin
      unique case (paddr)
        ADDR_OV_THR: r_d.ovThr = pwdata[15:0];
        ADDR_OV_METHOD: r_d.ovMethod = pwdata[0];
        ADDR_ACC_THR: r_d.accThr = wrPct;
        ADDR_RUN_THR: r_d.runThr = wrPct;
        ADDR_RAMP_SEL: begin
          if (pwdata[15:0] <= 16'(RAMP_SEL_AUTO)) begin
            r_d.rampSel = pwdata[2:0];
          end
        end
        ADDR_CTRL: begin
          r_d.torqueDuty = pwdata[CTRL_DUTY_BIT];
          r_d.voltClass = pwdata[CTRL_CLASS_LSB +: 2];
          if (pwdata[CTRL_DUTY_BIT] != r_q.torqueDuty) begin
            r_d.accThr = dutyDef;
            r_d.runThr = dutyDef;
          end
        end
        ADDR_RATED: r_d.ratedCur = pwdata[15:0];
        default: r_d.ratedCur = r_q.ratedCur;
      endcase
    end
    // ramp engine
    r_d.ovStall = 1'b0;
    r_d.ocStall = 1'b0;
    stepRate = {16'h0000, rateActive};
    unique case (r_q.state)
      ST_NORMAL: begin
        if (accelReq) begin
          if (accHigh) begin
            r_d.ocStall = 1'b1;
          end else begin
            upSum = {1'b0, r_q.freqAcc} + {1'b0, stepRate};
            upStep = (upSum > {1'b0, target}) ? target : upSum[31:0];
            r_d.freqAcc = upStep;
          end
        end else if (decelReq) begin
          if (ovEn && busHigh) begin
            r_d.ovStall = 1'b1;
            stepRate = '0;
          end else if (ovEn && r_q.ovMethod && busNear) begin
            r_d.ovStall = 1'b1;
            stepRate = {18'h0, rateActive[15:2]};
          end
          downStep = (r_q.freqAcc - target > stepRate) ? r_q.freqAcc - stepRate : target;
          r_d.freqAcc = downStep;
        end else if (runHigh) begin
          r_d.state = ST_REDUCE;
          r_d.ocStall = 1'b1;
        end
      end
      ST_REDUCE: begin
        r_d.ocStall = 1'b1;
        if (runHigh) begin
          stepRate = {16'h0000, selRate};
          downStep = (r_q.freqAcc > stepRate) ? r_q.freqAcc - stepRate : 32'h00000000;
          r_d.freqAcc = downStep;
        end else begin
          r_d.state = ST_RECOVER;
        end
      end
      ST_RECOVER: begin
        r_d.ocStall = 1'b1;
        if (runHigh) begin
          r_d.state = ST_REDUCE;
        end else if (!accelReq) begin
          r_d.state = ST_NORMAL;
          r_d.ocStall = 1'b0;
        end else begin
          stepRate = {16'h0000, selRate};
          upSum = {1'b0, r_q.freqAcc} + {1'b0, stepRate};
          upStep = (upSum > {1'b0, target}) ? target : upSum[31:0];
          r_d.freqAcc = upStep;
        end
      end
    endcase
    r_d.outFreq = r_d.freqAcc[31:16];
  end

  // ********************************
  // registers
  // ********************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      r_q <= '0;
      r_q.ovThr <= RST_OV_THR;
      r_q.ovMethod <= RST_OV_METHOD;
      r_q.accThr <= DEF_THR_VT;
      r_q.runThr <= DEF_THR_VT;
      r_q.rampSel <= RST_RAMP_SEL;
      r_q.torqueDuty <= RST_DUTY;
      r_q.voltClass <= RST_CLASS;
      r_q.ratedCur <= RST_RATED;
      r_q.state <= ST_NORMAL;
    end else begin
      r_q <= r_d;
    end
  end

  assign ovStallActive = r_q.ovStall;
  assign ocStallActive = r_q.ocStall;
  assign outFreq = r_q.outFreq;
  assign prdata = r_q.prdata;
  assign pready = r_q.pready;
  assign pslverr = r_q.pslverr;

  // ********************************
  // assertions
  // ********************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  property p_trad_hold;
    (r_q.state == ST_NORMAL && decelReq && ovEn && busHigh) |=> $stable(r_q.freqAcc);
  endproperty
  a_trad_hold: assert property (p_trad_hold) else $error("decel not frozen on high bus");

  property p_smart_slow;
    (r_q.state == ST_NORMAL && decelReq && ovEn && r_q.ovMethod && !busHigh && busNear)
      |=> ($past(r_q.freqAcc) - r_q.freqAcc) <= {18'h0, $past(rateActive[15:2])};
  endproperty
  a_smart_slow: assert property (p_smart_slow) else $error("smart decel too fast");

  property p_ov_off;
    (!ovEn && r_q.state == ST_NORMAL) |=> !r_q.ovStall ##1 1'b1;
  endproperty
  a_ov_off: assert property (p_ov_off) else $error("ov stall with zero threshold");

  property p_range;
    r_q.accThr <= MAX_PCT_CT && r_q.runThr <= MAX_PCT_CT;
  endproperty
  a_range: assert property (p_range) else $error("threshold out of range");

  property p_duty_default;
    (access && pwrite && paddr == ADDR_CTRL && pwdata[0] != r_q.torqueDuty)
      |=> r_q.accThr == (r_q.torqueDuty ? DEF_THR_CT : DEF_THR_VT);
  endproperty
  a_duty_default: assert property (p_duty_default) else $error("default not loaded");

  property p_cap;
    capHigh |-> effAcc <= CAP_PCT_HIGH_BUS && effRun <= CAP_PCT_HIGH_BUS;
  endproperty
  a_cap: assert property (p_cap) else $error("high bus cap missed");

  property p_acc_hold;
    (r_q.state == ST_NORMAL && accelReq && accHigh) |=> $stable(r_q.freqAcc) && r_q.ocStall;
  endproperty
  a_acc_hold: assert property (p_acc_hold) else $error("accel not held");

  property p_reduce;
    (r_q.state == ST_NORMAL && !accelReq && !decelReq && runHigh) |=> r_q.state == ST_REDUCE;
  endproperty
  a_reduce: assert property (p_reduce) else $error("no reduction on overload");

  property p_recover;
    (r_q.state == ST_REDUCE && !runHigh) |=> r_q.state == ST_RECOVER ##1 r_q.ocStall;
  endproperty
  a_recover: assert property (p_recover) else $error("no recovery");

  property p_auto_sel;
    r_q.rampSel == RAMP_SEL_AUTO |-> selRate == rateAuto;
  endproperty
  a_auto_sel: assert property (p_auto_sel) else $error("auto ramp not chosen");

  c_trad: cover property (r_q.state == ST_NORMAL && decelReq && ovEn && busHigh);
  c_acc: cover property (r_q.ocStall && accelReq && r_q.state == ST_NORMAL);
  c_cycle: cover property (r_q.state == ST_REDUCE ##[1:50] r_q.state == ST_RECOVER);

endmodule

// ===== sim/srpc_motor_model.sv
// power stage and motor stand-in: current and bus sensor lines
module srpc_motor_model (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [15:0] outFreq,
  input wire logic [15:0] loadCur,
  input wire logic [15:0] busBase,
  output logic [15:0] outputCurrent,
  output logic [15:0] busVoltage
);
  timeunit 1ns;
  timeprecision 100ps;
  // sensors follow load and bus one clock late; light ripple at speed
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      outputCurrent <= 16'h0000;
      busVoltage <= 16'h0000;
    end else begin
      outputCurrent <= loadCur + {15'h0, outFreq[0]};
      busVoltage <= busBase;
    end
  end
endmodule

// ===== sim/srpc_ramp_ctrl_test.sv
// testbench for the stall prevention ramp supervisor
module srpc_ramp_ctrl_test;
  import srpc_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk, arst_n, psel, penable, pwrite, pready, pslverr, ovStallActive, ocStallActive;
  logic [15:0] paddr, outputCurrent, busVoltage, cmdFreq, rateActive, outFreq, loadCur, busBase;
  logic [31:0] pwdata, prdata, rd;
  logic err;
  int fails, cmp_count;

  srpc_ramp_ctrl DUT (.mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .outputCurrent(outputCurrent), .busVoltage(busVoltage),
    .cmdFreq(cmdFreq), .rateActive(rateActive), .rateSet1(16'h4000), .rateSet2(16'h2000),
    .rateSet3(16'h1000), .rateSet4(16'h0800), .rateAuto(16'h6000), .outFreq(outFreq),
    .ovStallActive(ovStallActive), .ocStallActive(ocStallActive));
  srpc_motor_model PM (.mclk(mclk), .arst_n(arst_n), .outFreq(outFreq), .loadCur(loadCur),
    .busBase(busBase), .outputCurrent(outputCurrent), .busVoltage(busVoltage));

  // ********************************
  // shared tasks
  // ********************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge mclk);
      n++;
    end
    if (n == 50) fails++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic waitf(input logic [15:0] f, input int lim);
    int n;
    n = 0;
    while (outFreq !== f && n < lim) begin
      @(posedge mclk);
      n++;
    end
    chk(outFreq, f);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // ********************************
  // scenarios
  // ********************************
  task automatic t_regs();
    apb(1'b0, ADDR_OV_METHOD, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, ADDR_ACC_THR, 32'h0);
    chk(rd, 32'd120);
    apb(1'b0, ADDR_RAMP_SEL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 16'h1F00, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, ADDR_RUN_THR, 32'd300);
    apb(1'b0, ADDR_RUN_THR, 32'h0);
    chk(rd, 32'd150);
    apb(1'b1, ADDR_CTRL, 32'h1);
    apb(1'b0, ADDR_ACC_THR, 32'h0);
    chk(rd, 32'd180);
    apb(1'b1, ADDR_ACC_THR, 32'd250);
    apb(1'b0, ADDR_ACC_THR, 32'h0);
    chk(rd, 32'd200);
    apb(1'b1, ADDR_CTRL, 32'h0);
    apb(1'b1, ADDR_RAMP_SEL, 32'h6);
    apb(1'b0, ADDR_RAMP_SEL, 32'h0);
    chk(rd, 32'h0);
    for (int s = 5; s >= 0; s--) begin
      apb(1'b1, ADDR_RAMP_SEL, 32'(s));
      apb(1'b0, ADDR_RAMP_SEL, 32'h0);
      chk(rd, 32'(s));
    end
  endtask

  task automatic t_accel_hold();
    loadCur <= 16'd400;
    cmdFreq <= 16'd10;
    idle(40);
    chk(outFreq, 16'd1);
    chk(ocStallActive, 1'b1);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd[ST_OC_BIT], 1'b1);
    loadCur <= 16'd0;
    waitf(16'd10, 80);
  endtask

  task automatic t_run_reduce();
    apb(1'b1, ADDR_RAMP_SEL, 32'h1);
    loadCur <= 16'd400;
    idle(30);
    chk(outFreq < 16'd10, 1'b1);
    chk(ocStallActive, 1'b1);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd[ST_REDUCE_BIT], 1'b1);
    loadCur <= 16'd0;
    waitf(16'd10, 200);
    idle(6);
    chk(ocStallActive, 1'b0);
  endtask

  task automatic t_ov_hold();
    busBase <= 16'd4000;
    idle(6);
    cmdFreq <= 16'd0;
    idle(40);
    chk(outFreq, 16'd10);
    chk(ovStallActive, 1'b1);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd[ST_OV_BIT], 1'b1);
    chk(rd[ST_FREQ_LSB +: 16], 16'd10);
    busBase <= 16'd3000;
    waitf(16'd0, 80);
  endtask

  task automatic t_smart();
    apb(1'b1, ADDR_OV_METHOD, 32'h1);
    cmdFreq <= 16'd10;
    waitf(16'd10, 80);
    busBase <= 16'd3750;
    cmdFreq <= 16'd0;
    idle(26);
    chk(outFreq !== 16'd0, 1'b1);
    chk(ovStallActive, 1'b1);
    waitf(16'd0, 200);
    busBase <= 16'd3000;
    apb(1'b1, ADDR_OV_METHOD, 32'h0);
  endtask

  task automatic t_cap();
    apb(1'b1, ADDR_CTRL, 32'h1);
    apb(1'b1, ADDR_ACC_THR, 32'd200);
    apb(1'b1, ADDR_RUN_THR, 32'd200);
    busBase <= 16'd3600;
    idle(6);
    loadCur <= 16'd490;
    cmdFreq <= 16'd10;
    idle(20);
    chk(outFreq, 16'd1);
    chk(ocStallActive, 1'b1);
    busBase <= 16'd3000;
    waitf(16'd10, 80);
    loadCur <= 16'd0;
    cmdFreq <= 16'd0;
    waitf(16'd0, 80);
    apb(1'b1, ADDR_CTRL, 32'h0);
  endtask

  task automatic t_ov_off();
    apb(1'b1, ADDR_OV_THR, 32'h0);
    cmdFreq <= 16'd10;
    waitf(16'd10, 80);
    busBase <= 16'd4000;
    cmdFreq <= 16'd0;
    waitf(16'd0, 40);
    chk(ovStallActive, 1'b0);
  endtask

  // ********************************
  // closing and main sequence
  // ********************************
  task automatic wrap_up();
    if (fails == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  initial begin
    #(40000 * 4);
    fails++;
    wrap_up();
  end

  initial begin
    fails = 0;
    cmp_count = 0;
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h0;
    cmdFreq = 16'h0000;
    rateActive = 16'h8000;
    loadCur = 16'h0000;
    busBase = 16'd3000;
    repeat (16) @(posedge mclk);
    arst_n <= 1'b1;
    t_regs();
    t_accel_hold();
    t_run_reduce();
    t_ov_hold();
    t_smart();
    t_cap();
    t_ov_off();
    wrap_up();
  end
endmodule
